/* inc/wdt_pkg.sv */
package wdt_pkg;

   // Register byte offsets.
   localparam logic [4:0] OFS_CONTROL = 5'h00;
   localparam logic [4:0] OFS_RESTART = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_COUNT0 = 5'h0C;
   localparam logic [4:0] OFS_COUNT1 = 5'h10;
   localparam logic [4:0] OFS_COUNT2 = 5'h14;
   localparam logic [4:0] OFS_COUNT3 = 5'h18;

   // Control field positions.
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_RESPONSE_BIT = 1;
   localparam int CTL_LOCK_BIT = 3;
   localparam int CTL_PERIOD_LSB = 4;
   localparam int PERIOD_W = 4;

   // Status field positions.
   localparam int STS_RESP_LSB = 4;
   localparam int STS_ONE_BIT = 6;
   localparam int STS_IRQ_BIT = 7;

   // Restart key and period base exponent.
   localparam logic [15:0] RESTART_KEY = 16'h1984;
   localparam int PERIOD_BASE_EXP = 16;

   // Reset values.
   localparam logic [3:0] PERIOD_RST = 4'h0;
   localparam logic [31:0] COUNT_RST = 32'h0001_0000;

   // Bus request carried as one bundle.
   typedef struct packed {
      logic sel;
      logic wr;
      logic [4:0] addr;
      logic [31:0] wdata;
   } bus_req_s;

   typedef enum logic [1:0] {
      ARMED,
      WARNED
   } wdt_state_e;

endpackage

/* logic/wdt_rdata_mux.sv */
`timescale 1ns/1ps
module wdt_rdata_mux (
   input wire logic clk_sys_i, // System clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic rd_i, // Read strobe.
   input wire logic [4:0] addr_i, // Byte offset.
   input wire logic [7:0] control_i, // Control low byte.
   input wire logic [7:0] status_i, // Status low byte.
   input wire logic [31:0] count_i, // Live count.
   output logic [31:0] rdata_o // Registered read data.
);

   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   // Unmapped and write-only offsets read as zero; upper bits always zero.
   always_comb begin
      rdata_d = rdata_q;
      if (rd_i) begin
         case (addr_i)
            wdt_pkg::OFS_CONTROL: rdata_d = {24'h000000, control_i};
            wdt_pkg::OFS_STATUS: rdata_d = {24'h000000, status_i};
            wdt_pkg::OFS_COUNT0: rdata_d = {24'h000000, count_i[7:0]};
            wdt_pkg::OFS_COUNT1: rdata_d = {24'h000000, count_i[15:8]};
            wdt_pkg::OFS_COUNT2: rdata_d = {24'h000000, count_i[23:16]};
            wdt_pkg::OFS_COUNT3: rdata_d = {24'h000000, count_i[31:24]};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // Holding the last answer keeps the port stable between reads.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata_o = rdata_q;

endmodule

/* logic/watchdog_timer.sv */
`timescale 1ns/1ps
module watchdog_timer #(
   parameter int COUNT_W = 32 // Counter width.
) (
   input wire logic clk_sys_i, // System clock, 100 MHz.
   input wire logic rst_i, // Synchronous system reset, active high.
   input wire logic bus_sel_i, // Register access strobe.
   input wire logic bus_wr_i, // 1 write, 0 read.
   input wire logic [4:0] bus_addr_i, // Byte offset.
   input wire logic [31:0] bus_wdata_i, // Write data.
   output logic [31:0] bus_rdata_o, // Read data, one cycle after the read.
   output logic irq_o, // Watchdog interrupt, active high.
   output logic reset_req_o // Reset request pulse to the reset controller.
);

   // Bus request bundle and the strobes decoded from it.
   wdt_pkg::bus_req_s req;
   logic ctl_wr;
   logic key_hit;
   logic rd_strobe;

   // Control fields held between accesses.
   logic enable_q;
   logic enable_d;
   logic response_select_q;
   logic response_select_d;
   logic enable_lock_q;
   logic enable_lock_d;
   logic [3:0] period_q;
   logic [3:0] period_d;

   // Down-counter, its reload value and the timeout it produces.
   logic [COUNT_W-1:0] count_q;
   logic [COUNT_W-1:0] count_d;
   logic [COUNT_W-1:0] reload_val;
   logic timeout;

   // Timeout response state.
   logic irq_q;
   logic irq_d;
   logic reset_req_q;
   logic reset_req_d;
   wdt_pkg::wdt_state_e state_q;
   wdt_pkg::wdt_state_e state_d;

   // Readback views.
   logic [7:0] control_rd;
   logic [7:0] status_rd;

   // Write strobe for one offset; control and restart decode through the same test.
   function automatic logic wr_hit(input wdt_pkg::bus_req_s r, input logic [4:0] ofs);
      return r.sel && r.wr && r.addr == ofs;
   endfunction

   // Accesses last one cycle, so the decode stays combinational and adds no latency.
   // The key is compared on the low half only; the upper half of that write is ignored.
   assign req = '{sel: bus_sel_i, wr: bus_wr_i, addr: bus_addr_i, wdata: bus_wdata_i};
   assign ctl_wr = wr_hit(req, wdt_pkg::OFS_CONTROL);
   assign key_hit = wr_hit(req, wdt_pkg::OFS_RESTART) && req.wdata[15:0] == wdt_pkg::RESTART_KEY;
   assign rd_strobe = req.sel && !req.wr;

   // A timeout is a zero count seen while enabled; a disabled block never times out.
   assign timeout = enable_q && count_q == '0;

   // Reload value for a period code; shared by restart and timeout paths.
   // The set bit sits at sixteen plus the code, so the widest code needs all 32 counter bits.
   function automatic logic [COUNT_W-1:0] reload_of(input logic [3:0] code);
      logic [COUNT_W-1:0] v;
      v = '0;
      v[wdt_pkg::PERIOD_BASE_EXP + int'(code)] = 1'b1;
      return v;
   endfunction

   // One reload value feeds both reload branches, so they can never disagree.
   assign reload_val = reload_of(period_q);

   // Control register; the lock can only be set, and while set enable cannot drop.
   // The lock is judged on its value before the write, so the write that sets it may
   // still clear enable; only later writes are held off.
   always_comb begin
      enable_d = enable_q;
      response_select_d = response_select_q;
      enable_lock_d = enable_lock_q;
      period_d = period_q;
      if (ctl_wr) begin
         period_d = req.wdata[wdt_pkg::CTL_PERIOD_LSB +: wdt_pkg::PERIOD_W];
         response_select_d = req.wdata[wdt_pkg::CTL_RESPONSE_BIT];
         enable_lock_d = enable_lock_q | req.wdata[wdt_pkg::CTL_LOCK_BIT];
         enable_d = req.wdata[wdt_pkg::CTL_ENABLE_BIT] | (enable_lock_q & enable_q);
      end
   end

   // Control flip-flops; a system reset is the only way back to an unlocked state.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         enable_q <= 1'b0;
         response_select_q <= 1'b0;
         enable_lock_q <= 1'b0;
         period_q <= wdt_pkg::PERIOD_RST;
      end else begin
         enable_q <= enable_d;
         response_select_q <= response_select_d;
         enable_lock_q <= enable_lock_d;
         period_q <= period_d;
      end
   end

   // Counter: the period is sampled only on reload, so a changed code waits.
   // The zero count stands for one cycle before the reload, so one period spans the
   // selected count plus one cycle; a restart while disabled still reloads.
   always_comb begin
      count_d = count_q;
      if (key_hit) begin
         count_d = reload_val;
      end else if (timeout) begin
         count_d = reload_val;
      end else if (enable_q) begin
         count_d = count_q - COUNT_W'(1);
      end
   end

   // Counter flip-flops; reset leaves the shortest period loaded.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         count_q <= wdt_pkg::COUNT_RST[COUNT_W-1:0];
      end else begin
         count_q <= count_d;
      end
   end

   // Timeout response. A keyed restart in the timeout cycle wins, since the count is reloaded.
   // The warned state and the interrupt flag move together: both are entered on the first
   // timeout in interrupt mode and both leave only on a keyed restart or a reset.
   // Software that lets the interrupt stand therefore gets a reset request at every later timeout.
   always_comb begin
      irq_d = irq_q;
      state_d = state_q;
      reset_req_d = 1'b0;
      if (key_hit) begin
         irq_d = 1'b0;
         state_d = wdt_pkg::ARMED;
      end else if (timeout) begin
         case (state_q)
            wdt_pkg::ARMED: begin
               if (response_select_q) begin
                  irq_d = 1'b1;
                  state_d = wdt_pkg::WARNED;
               end else begin
                  reset_req_d = 1'b1;
               end
            end
            wdt_pkg::WARNED: begin
               state_d = wdt_pkg::WARNED;
               reset_req_d = 1'b1;
            end
            default: state_d = wdt_pkg::ARMED;
         endcase
      end
   end

   // Response flip-flops; the request is cleared by default every cycle, so it only
   // ever pulses for one cycle per reset-generating timeout.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
         state_q <= wdt_pkg::ARMED;
         reset_req_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         state_q <= state_d;
         reset_req_q <= reset_req_d;
      end
   end

   // Control readback; reserved bits are tied low rather than stored, so writes to them
   // are lost and they always read as zero.
   always_comb begin
      control_rd = '0;
      control_rd[wdt_pkg::CTL_PERIOD_LSB +: wdt_pkg::PERIOD_W] = period_q;
      control_rd[wdt_pkg::CTL_LOCK_BIT] = enable_lock_q;
      control_rd[wdt_pkg::CTL_RESPONSE_BIT] = response_select_q;
      control_rd[wdt_pkg::CTL_ENABLE_BIT] = enable_q;
   end

   // Status readback; the response field is the one control bit shown twice, and bit 6
   // is a constant one.
   always_comb begin
      status_rd = '0;
      status_rd[wdt_pkg::STS_IRQ_BIT] = irq_q;
      status_rd[wdt_pkg::STS_ONE_BIT] = 1'b1;
      status_rd[wdt_pkg::STS_RESP_LSB +: 2] = {2{response_select_q}};
   end

   // Read data are registered inside the mux, which keeps the bus output on a flip-flop
   // at the cost of one cycle of read latency.
   wdt_rdata_mux u_rdata (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .rd_i(rd_strobe),
      .addr_i(req.addr),
      .control_i(control_rd),
      .status_i(status_rd),
      .count_i(32'(count_q)),
      .rdata_o(bus_rdata_o)
   );

   // Outputs straight from flip-flops, so the reset controller sees no combinational
   // path from the register bus.
   assign irq_o = irq_q;
   assign reset_req_o = reset_req_q;

endmodule

/* dv/wdt_props.sv */
`timescale 1ns/1ps
module wdt_props (
   input wire logic clk_sys_i, // Clock.
   input wire logic rst_i, // Reset.
   input wire logic bus_sel_i, // Strobe.
   input wire logic bus_wr_i, // Write.
   input wire logic [4:0] bus_addr_i, // Offset.
   input wire logic [31:0] bus_wdata_i, // Write data.
   input wire logic [31:0] bus_rdata_o, // Read data.
   input wire logic irq_o, // Interrupt.
   input wire logic reset_req_o // Reset request.
);
   // Decoded accesses; read data lands one cycle after the strobe.
   logic rd;
   logic key;
   assign rd = bus_sel_i && !bus_wr_i;
   assign key = bus_sel_i && bus_wr_i && bus_addr_i == 5'h04 && bus_wdata_i[15:0] == 16'h1984;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_req_pulse: assert property (reset_req_o |=> !reset_req_o)
      else $error("Reset request held too long.");
   a_key_clears: assert property (key |=> !irq_o)
      else $error("Keyed restart left interrupt set.");
   a_irq_holds: assert property (irq_o && !key |=> irq_o)
      else $error("Interrupt dropped without restart.");
   a_first_warn: assert property ($rose(irq_o) |-> !reset_req_o)
      else $error("First timeout also requested reset.");
   a_status_fixed: assert property (rd && bus_addr_i == 5'h08 |=> bus_rdata_o[31:8] == 24'h0 &&
      bus_rdata_o[6] && bus_rdata_o[5] == bus_rdata_o[4] && bus_rdata_o[3:0] == 4'h0)
      else $error("Status fixed bits wrong.");
   a_status_irq: assert property (rd && bus_addr_i == 5'h08 |=> bus_rdata_o[7] == $past(irq_o))
      else $error("Status interrupt bit wrong.");
   a_count_byte: assert property (rd && bus_addr_i >= 5'h0C && bus_addr_i <= 5'h18 |=> bus_rdata_o[31:8] == 24'h0)
      else $error("Count upper bits not zero.");
   a_restart_zero: assert property (rd && bus_addr_i == 5'h04 |=> bus_rdata_o == 32'h0)
      else $error("Restart register read not zero.");
   a_rdata_holds: assert property (!rd |=> $stable(bus_rdata_o))
      else $error("Read data changed without a read.");
endmodule
bind watchdog_timer wdt_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_sel_i(bus_sel_i),
   .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
   .irq_o(irq_o), .reset_req_o(reset_req_o));

/* dv/tb_watchdog_timer.sv */
`timescale 1ns/1ps
module tb_watchdog_timer;
   `define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end end
   logic clk_sys_i = 1'b0, rst_i = 1'b1, bus_sel_i = 1'b0, bus_wr_i = 1'b0;
   logic [4:0] bus_addr_i = 5'h00;
   logic [31:0] bus_wdata_i = 32'h00000000, bus_rdata_o, m_cnt, m_rd;
   logic irq_o, reset_req_o, m_irq, m_req;
   logic [7:0] m_ctl;
   int failures = 0, samples_checked = 0, seed = 32'h3FA703B9;
   watchdog_timer uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_sel_i(bus_sel_i), .bus_wr_i(bus_wr_i),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .irq_o(irq_o),
      .reset_req_o(reset_req_o));
   // Free-running system clock.
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Reference model; it sees the same pre-edge inputs as the design, so it stays cycle exact.
   always @(posedge clk_sys_i) begin
      if (!rst_i) `CHK("irq", m_irq, irq_o)
      if (!rst_i) `CHK("reset_req", m_req, reset_req_o)
      m_req = 1'b0;
      if (rst_i) begin
         m_ctl = 8'h00;
         m_cnt = 32'h00010000;
         m_irq = 1'b0;
      end else begin
         if (bus_sel_i && !bus_wr_i) case (bus_addr_i)
            5'h00: m_rd = {24'h000000, m_ctl};
            5'h08: m_rd = {24'h000000, m_irq, 1'b1, m_ctl[1], m_ctl[1], 4'h0};
            5'h0C, 5'h10, 5'h14, 5'h18: m_rd = (m_cnt >> ((bus_addr_i - 5'h0C) * 5'h02)) & 32'h000000FF;
            default: m_rd = 32'h00000000;
         endcase
         if (bus_sel_i && bus_wr_i && bus_addr_i == 5'h04 && bus_wdata_i[15:0] == 16'h1984) begin
            m_cnt = 32'h00000001 << (16 + m_ctl[7:4]);
            m_irq = 1'b0;
         end else if (m_ctl[0] && m_cnt == 32'h00000000) begin
            m_cnt = 32'h00000001 << (16 + m_ctl[7:4]);
            if (m_ctl[1] && !m_irq) m_irq = 1'b1;
            else m_req = 1'b1;
         end else if (m_ctl[0]) m_cnt = m_cnt - 32'h00000001;
         if (bus_sel_i && bus_wr_i && bus_addr_i == 5'h00)
            m_ctl = (bus_wdata_i[7:0] & 8'hFB) | (m_ctl & 8'h08) | {7'h00, m_ctl[3] & m_ctl[0]};
      end
   end
   // One register access; the read result is checked once it has landed.
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      bus_sel_i <= 1'b1;
      bus_wr_i <= w;
      bus_addr_i <= a;
      bus_wdata_i <= d;
      @(posedge clk_sys_i);
      bus_sel_i <= 1'b0;
      #1;
      if (!w) `CHK("rdata", m_rd, bus_rdata_o)
   endtask
   // Verdict and end of run.
   task automatic conclude();
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence; the single timeout wait is the long part of the run.
   initial begin
      int i;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (i = 0; i < 8; i++) acc(1'b0, 5'(i * 4), 32'h00000000);
      for (i = 0; i < 16; i++) begin
         acc(1'b1, 5'h00, {24'h000000, 4'(i), 4'h0});
         acc(1'b1, 5'h04, ($random(seed) & 32'hFFFF0000) | 32'h00001984);
         acc(1'b0, 5'h14, 32'h00000000);
         acc(1'b0, 5'h18, 32'h00000000);
      end
      acc(1'b1, 5'h00, 32'h0000000B);
      acc(1'b0, 5'h18, 32'h00000000);
      acc(1'b1, 5'h04, 32'h00001984);
      acc(1'b1, 5'h04, $random(seed) | 32'h00000001);
      acc(1'b1, 5'h00, 32'h000000F6);
      acc(1'b0, 5'h00, 32'h00000000);
      acc(1'b0, 5'h08, 32'h00000000);
      for (i = 0; i < 70000 && irq_o !== 1'b1; i++) @(posedge clk_sys_i);
      if (i == 70000) begin
         failures++;
      end else begin
         for (i = 0; i < 4; i++) acc(1'b0, 5'($random(seed)) & 5'h1C, 32'h00000000);
         acc(1'b0, 5'h08, 32'h00000000);
         acc(1'b1, 5'h04, 32'h00001984);
         acc(1'b0, 5'h08, 32'h00000000);
         // Mid-run reset: the only way to unlock the enable; it also restores the shortest period.
         @(posedge clk_sys_i);
         rst_i <= 1'b1;
         repeat (3) @(posedge clk_sys_i);
         rst_i <= 1'b0;
         acc(1'b0, 5'h00, 32'h00000000);
         acc(1'b0, 5'h14, 32'h00000000);
      end
      conclude();
   end
endmodule
